/* hdl/mog_pkg.sv */
// constants shared by the motor overload guard
package mog_pkg;

    // ------------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_MS = 100;
    localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int TICKS_PER_S    = 1000 / TICK_PERIOD_MS;
    localparam int TICKS_PER_MIN  = 60 * TICKS_PER_S;

    // ------------------------------------------------------------------
    // curve points: level in 0.1 % of rated current, time in minutes and in ticks
    // ------------------------------------------------------------------
    localparam logic [11:0] LVL_115 = 12'h47E;  // 115.0 %
    localparam logic [11:0] LVL_125 = 12'h4E2;  // 125.0 %
    localparam logic [11:0] LVL_145 = 12'h5AA;  // 145.0 %
    localparam logic [11:0] LVL_155 = 12'h60E;  // 155.0 %
    localparam logic [11:0] LVL_175 = 12'h6D6;  // 175.0 %

    localparam int TRIP_115_MIN = 80;
    localparam int TRIP_125_MIN = 40;
    localparam int TRIP_145_MIN = 6;
    localparam int TRIP_155_MIN = 4;
    localparam int TRIP_175_MIN = 2;
    localparam int MAX_TRIP_MIN = 80;
    localparam int MIN_TRIP_S   = 10;

    localparam logic [15:0] TRIP_115_TICKS = 16'(TRIP_115_MIN * TICKS_PER_MIN);
    localparam logic [15:0] TRIP_125_TICKS = 16'(TRIP_125_MIN * TICKS_PER_MIN);
    localparam logic [15:0] TRIP_145_TICKS = 16'(TRIP_145_MIN * TICKS_PER_MIN);
    localparam logic [15:0] TRIP_155_TICKS = 16'(TRIP_155_MIN * TICKS_PER_MIN);
    localparam logic [15:0] TRIP_175_TICKS = 16'(TRIP_175_MIN * TICKS_PER_MIN);
    localparam logic [15:0] MAX_TRIP_TICKS = 16'(MAX_TRIP_MIN * TICKS_PER_MIN);
    localparam logic [15:0] MIN_TRIP_TICKS = 16'(MIN_TRIP_S * TICKS_PER_S);

    // ------------------------------------------------------------------
    // gain in 0.01 steps, coefficient in percent
    // ------------------------------------------------------------------
    localparam logic [9:0] GAIN_UNITY = 10'h064;  // 1.00
    localparam logic [9:0] GAIN_MIN   = 10'h014;  // 0.20
    localparam logic [9:0] GAIN_MAX   = 10'h3E8;  // 10.00
    localparam logic [6:0] COEF_DFLT  = 7'h50;    // 80 %
    localparam logic [6:0] COEF_MIN   = 7'h32;    // 50 %
    localparam logic [6:0] COEF_FULL  = 7'h64;    // 100 %

    // ------------------------------------------------------------------
    // fault code and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] FAULT_CODE_OVERLOAD = 16'h0B00;  // 11.00
    localparam logic [15:0] FAULT_CODE_NONE     = 16'h0000;
    localparam logic [15:0] ACC_RST             = 16'h0000;

endpackage

/* hdl/mog_tick.sv */
// time base: one pulse every TICK_CYCLES clocks, realigned on restart
`timescale 1ns/1ps
`default_nettype none
module mog_tick
    import mog_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // control
    input  wire logic restart_i,
    output logic      tick_o
);

    logic [31:0] cnt_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 32'h00000000;
            tick_o  <= 1'b0;
        end else if (restart_i) begin
            cnt_reg <= 32'h00000000;
            tick_o  <= 1'b0;
        end else if (cnt_reg == 32'(TICK_CYCLES_P - 1)) begin
            cnt_reg <= 32'h00000000;
            tick_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
            tick_o  <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* hdl/mog_curve.sv */
// inverse time curve lookup, interpolation, gain and pre-warning scaling
`timescale 1ns/1ps
`default_nettype none
module mog_curve
    import mog_pkg::*;
(
    // operating point
    input  wire logic [11:0] level_i,
    input  wire logic [9:0]  gain_i,
    input  wire logic [6:0]  coef_i,
    // results
    output logic             over_o,
    output logic [15:0]      trip_o,
    output logic [15:0]      warn_o
);

    function automatic logic [15:0] interp(input logic [11:0] lvl, input logic [11:0] i1,
                                           input logic [11:0] i2, input logic [15:0] t1,
                                           input logic [15:0] t2);
        logic [31:0] dec;
        dec = 32'(t1 - t2) * 32'(lvl - i1) / 32'(i2 - i1);
        return t1 - dec[15:0];
    endfunction

    logic [15:0] t_curve;
    logic [31:0] scaled;
    logic [31:0] warn_w;

    always_comb begin
        over_o = (level_i >= LVL_115);
        if (level_i < LVL_115) begin
            t_curve = TRIP_115_TICKS;
        end else if (level_i < LVL_125) begin
            t_curve = interp(level_i, LVL_115, LVL_125, TRIP_115_TICKS, TRIP_125_TICKS);
        end else if (level_i < LVL_145) begin
            t_curve = interp(level_i, LVL_125, LVL_145, TRIP_125_TICKS, TRIP_145_TICKS);
        end else if (level_i < LVL_155) begin
            t_curve = interp(level_i, LVL_145, LVL_155, TRIP_145_TICKS, TRIP_155_TICKS);
        end else if (level_i < LVL_175) begin
            t_curve = interp(level_i, LVL_155, LVL_175, TRIP_155_TICKS, TRIP_175_TICKS);
        end else begin
            t_curve = TRIP_175_TICKS;
        end
        scaled = 32'(t_curve) * 32'(gain_i) / 32'(GAIN_UNITY);
        if (scaled > 32'(MAX_TRIP_TICKS)) begin
            trip_o = MAX_TRIP_TICKS;
        end else if (scaled < 32'(MIN_TRIP_TICKS)) begin
            trip_o = MIN_TRIP_TICKS;
        end else begin
            trip_o = scaled[15:0];
        end
        warn_w = 32'(trip_o) * 32'(coef_i) / 32'(COEF_FULL);
        warn_o = warn_w[15:0];
    end

endmodule
`default_nettype wire

/* hdl/mog_guard.sv */
// motor overload inverse time guard, top level
`timescale 1ns/1ps
`default_nettype none
module mog_guard
    import mog_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // measured running current, 0.1 % of rated
    input  wire logic [11:0] run_current_i,
    // settings
    input  wire logic        overload_protect_enable_i,
    input  wire logic [9:0]  overload_time_gain_i,
    input  wire logic [6:0]  prewarn_coefficient_i,
    input  wire logic        prewarn_to_relay_i,
    input  wire logic        fault_clear_i,
    // outputs to the control system
    output logic             do_prewarn_o,
    output logic             relay_prewarn_o,
    output logic             overload_fault_o,
    output logic [15:0]      motor_overload_fault_code_o,
    output logic [15:0]      acc_ticks_o
);

    // ------------------------------------------------------------------
    // setting normalisation
    // ------------------------------------------------------------------
    logic [9:0] gain_next;
    logic [6:0] coef_next;

    always_comb begin
        if (overload_time_gain_i == 10'h000) begin
            gain_next = GAIN_UNITY;
        end else if (overload_time_gain_i < GAIN_MIN) begin
            gain_next = GAIN_MIN;
        end else if (overload_time_gain_i > GAIN_MAX) begin
            gain_next = GAIN_MAX;
        end else begin
            gain_next = overload_time_gain_i;
        end
        if (prewarn_coefficient_i == 7'h00) begin
            coef_next = COEF_DFLT;
        end else if (prewarn_coefficient_i < COEF_MIN) begin
            coef_next = COEF_MIN;
        end else if (prewarn_coefficient_i > COEF_FULL) begin
            coef_next = COEF_FULL;
        end else begin
            coef_next = prewarn_coefficient_i;
        end
    end

    // ------------------------------------------------------------------
    // curve evaluation
    // ------------------------------------------------------------------
    logic        over_next;
    logic [15:0] trip_next;
    logic [15:0] warn_next;

    mog_curve u_curve (
        .level_i (run_current_i),
        .gain_i  (gain_next),
        .coef_i  (coef_next),
        .over_o  (over_next),
        .trip_o  (trip_next),
        .warn_o  (warn_next)
    );

    logic        over_reg;
    logic [15:0] trip_reg;
    logic [15:0] warn_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            over_reg <= 1'b0;
            trip_reg <= MAX_TRIP_TICKS;
            warn_reg <= MAX_TRIP_TICKS;
        end else begin
            over_reg <= over_next;
            trip_reg <= trip_next;
            warn_reg <= warn_next;
        end
    end

    // ------------------------------------------------------------------
    // time base
    // ------------------------------------------------------------------
    logic active;
    logic tick;

    assign active = overload_protect_enable_i && over_reg;

    mog_tick #(
        .TICK_CYCLES_P (TICK_CYCLES_P)
    ) u_tick (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .restart_i (!active),
        .tick_o    (tick)
    );

    // ------------------------------------------------------------------
    // overload accumulation
    // ------------------------------------------------------------------
    logic [15:0] acc_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_reg <= ACC_RST;
        end else if (!active) begin
            acc_reg <= ACC_RST;
        end else if (tick && acc_reg != 16'hFFFF) begin
            acc_reg <= acc_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // fault and pre-warning
    // ------------------------------------------------------------------
    logic fault_reg;
    logic prewarn_reg;
    logic trip_hit;
    logic warn_hit;

    assign trip_hit = active && (acc_reg >= trip_reg);
    assign warn_hit = active && (acc_reg >= warn_reg);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fault_reg <= 1'b0;
        end else if (!overload_protect_enable_i) begin
            fault_reg <= 1'b0;
        end else if (trip_hit) begin
            fault_reg <= 1'b1;
        end else if (fault_clear_i) begin
            fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prewarn_reg <= 1'b0;
        end else begin
            prewarn_reg <= warn_hit || trip_hit;
        end
    end

    // ------------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            do_prewarn_o                <= 1'b0;
            relay_prewarn_o             <= 1'b0;
            overload_fault_o            <= 1'b0;
            motor_overload_fault_code_o <= FAULT_CODE_NONE;
            acc_ticks_o                 <= ACC_RST;
        end else begin
            do_prewarn_o                <= prewarn_reg && !prewarn_to_relay_i;
            relay_prewarn_o             <= prewarn_reg && prewarn_to_relay_i;
            overload_fault_o            <= fault_reg;
            motor_overload_fault_code_o <= fault_reg ? FAULT_CODE_OVERLOAD : FAULT_CODE_NONE;
            acc_ticks_o                 <= acc_reg;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_disable_no_fault;
        @(posedge clk_i) disable iff (sys_rst_i)
        !overload_protect_enable_i |=> !fault_reg ##1 !overload_fault_o;
    endproperty
    a_disable_no_fault: assert property (p_disable_no_fault)
        else $error("fault present while protection disabled");

    property p_trip_125;
        @(posedge clk_i) disable iff (sys_rst_i)
        run_current_i == LVL_125 && gain_next == GAIN_UNITY |=> trip_reg == TRIP_125_TICKS;
    endproperty
    a_trip_125: assert property (p_trip_125)
        else $error("trip time at 125 percent is not 40 minutes");

    property p_trip_limits;
        @(posedge clk_i) disable iff (sys_rst_i)
        trip_reg >= MIN_TRIP_TICKS && trip_reg <= MAX_TRIP_TICKS;
    endproperty
    a_trip_limits: assert property (p_trip_limits)
        else $error("trip time outside 10 s to 80 min");

    property p_trip_max_clamp;
        @(posedge clk_i) disable iff (sys_rst_i)
        run_current_i == LVL_115 && overload_time_gain_i > GAIN_UNITY
        |=> trip_reg == MAX_TRIP_TICKS;
    endproperty
    a_trip_max_clamp: assert property (p_trip_max_clamp)
        else $error("trip time not held at 80 minutes");

    property p_gain_floor;
        @(posedge clk_i) disable iff (sys_rst_i)
        run_current_i == LVL_175 && overload_time_gain_i != 10'h000 && overload_time_gain_i < GAIN_MIN
        |=> trip_reg == 16'(TRIP_175_MIN * TICKS_PER_MIN / 5);
    endproperty
    a_gain_floor: assert property (p_gain_floor)
        else $error("gain below 0.20 not raised to 0.20");

    property p_trip_145_155;
        @(posedge clk_i) disable iff (sys_rst_i)
        gain_next == GAIN_UNITY && (run_current_i == LVL_145 || run_current_i == LVL_155)
        |=> trip_reg == ($past(run_current_i) == LVL_145 ? TRIP_145_TICKS : TRIP_155_TICKS);
    endproperty
    a_trip_145_155: assert property (p_trip_145_155)
        else $error("curve point at 145 or 155 percent wrong");

    property p_interp_150;
        @(posedge clk_i) disable iff (sys_rst_i)
        run_current_i == 12'h5DC && gain_next == GAIN_UNITY |=> trip_reg == 16'(5 * TICKS_PER_MIN);
    endproperty
    a_interp_150: assert property (p_interp_150)
        else $error("interpolated trip at 150 percent is not 5 minutes");

    property p_gain_scale;
        @(posedge clk_i) disable iff (sys_rst_i)
        run_current_i == 12'h5DC && overload_time_gain_i == 10'h028 |=> trip_reg == 16'(2 * TICKS_PER_MIN);
    endproperty
    a_gain_scale: assert property (p_gain_scale)
        else $error("gain 0.40 does not give 2 minutes at 150 percent");

    property p_warn_order;
        @(posedge clk_i) disable iff (sys_rst_i)
        warn_hit |=> prewarn_reg ##1 (do_prewarn_o || relay_prewarn_o);
    endproperty
    a_warn_order: assert property (p_warn_order)
        else $error("pre-warning not raised at warning time");

    property p_coef_default;
        @(posedge clk_i) disable iff (sys_rst_i)
        prewarn_coefficient_i == 7'h00 && run_current_i == LVL_145 && gain_next == GAIN_UNITY
        |=> warn_reg == 16'(TRIP_145_MIN * TICKS_PER_MIN * 8 / 10);
    endproperty
    a_coef_default: assert property (p_coef_default)
        else $error("default coefficient is not 80 percent");

    property p_full_coef;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(prewarn_reg) && $past(coef_next, 2) == COEF_FULL |-> fault_reg;
    endproperty
    a_full_coef: assert property (p_full_coef)
        else $error("pre-warning raised ahead of fault at full coefficient");

    property p_route;
        @(posedge clk_i) disable iff (sys_rst_i)
        prewarn_reg |=> (do_prewarn_o != relay_prewarn_o) && (relay_prewarn_o == $past(prewarn_to_relay_i));
    endproperty
    a_route: assert property (p_route)
        else $error("pre-warning routed to wrong output");

    property p_trip_ends;
        @(posedge clk_i) disable iff (sys_rst_i)
        gain_next == GAIN_UNITY && (run_current_i == LVL_175 || run_current_i == LVL_115)
        |=> trip_reg == ($past(run_current_i) == LVL_175 ? TRIP_175_TICKS : TRIP_115_TICKS);
    endproperty
    a_trip_ends: assert property (p_trip_ends)
        else $error("curve end point wrong");

    property p_acc_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        !over_reg |=> acc_reg == ACC_RST ##1 acc_ticks_o == ACC_RST;
    endproperty
    a_acc_clear: assert property (p_acc_clear)
        else $error("accumulator not cleared below curve");

    c_fault:   cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(overload_fault_o));
    c_do_warn: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(do_prewarn_o));
    c_relay:   cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(relay_prewarn_o));
    c_clear:   cover property (@(posedge clk_i) disable iff (sys_rst_i) $fell(overload_fault_o));
    c_together: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(prewarn_reg) && $rose(fault_reg));

endmodule
`default_nettype wire

/* tb/mog_ctrl_model.sv */
// control system model that counts overload events seen on the guard outputs
`timescale 1ns/1ps
`default_nettype none
module mog_ctrl_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // guard outputs
    input  wire logic       do_prewarn_i,
    input  wire logic       relay_prewarn_i,
    input  wire logic       overload_fault_i,
    // event counts
    output logic [7:0]      warn_cnt_o,
    output logic [7:0]      fault_cnt_o
);
    logic warn_reg;
    logic fault_reg;
    logic warn_next;

    // ------------------------------------------------------------------
    // edge counting
    // ------------------------------------------------------------------
    // either warning output
    assign warn_next = do_prewarn_i | relay_prewarn_i;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            warn_reg    <= 1'b0;
            fault_reg   <= 1'b0;
            warn_cnt_o  <= 8'h00;
            fault_cnt_o <= 8'h00;
        end else begin
            warn_reg  <= warn_next;
            fault_reg <= overload_fault_i;
            if (warn_next && !warn_reg) begin
                warn_cnt_o <= warn_cnt_o + 8'h01;
            end
            if (overload_fault_i && !fault_reg) begin
                fault_cnt_o <= fault_cnt_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking testbench for the motor overload guard
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mog_pkg::*;
    localparam int TCK = 4;

    logic        clk_i;
    logic        sys_rst_i;
    logic [11:0] run_current_i;
    logic        overload_protect_enable_i;
    logic [9:0]  overload_time_gain_i;
    logic [6:0]  prewarn_coefficient_i;
    logic        prewarn_to_relay_i;
    logic        fault_clear_i;
    logic        do_prewarn_o;
    logic        relay_prewarn_o;
    logic        overload_fault_o;
    logic [15:0] motor_overload_fault_code_o;
    logic [15:0] acc_ticks_o;
    logic [7:0]  warn_cnt;
    logic [7:0]  fault_cnt;
    int          num_errors;
    int          tests_run;

    mog_guard #(.TICK_CYCLES_P(TCK)) mog_guard_inst (
        .clk_i                       (clk_i),
        .sys_rst_i                   (sys_rst_i),
        .run_current_i               (run_current_i),
        .overload_protect_enable_i   (overload_protect_enable_i),
        .overload_time_gain_i        (overload_time_gain_i),
        .prewarn_coefficient_i       (prewarn_coefficient_i),
        .prewarn_to_relay_i          (prewarn_to_relay_i),
        .fault_clear_i               (fault_clear_i),
        .do_prewarn_o                (do_prewarn_o),
        .relay_prewarn_o             (relay_prewarn_o),
        .overload_fault_o            (overload_fault_o),
        .motor_overload_fault_code_o (motor_overload_fault_code_o),
        .acc_ticks_o                 (acc_ticks_o)
    );

    mog_ctrl_model mog_ctrl_model_inst (
        .clk_i            (clk_i),
        .sys_rst_i        (sys_rst_i),
        .do_prewarn_i     (do_prewarn_o),
        .relay_prewarn_i  (relay_prewarn_o),
        .overload_fault_i (overload_fault_o),
        .warn_cnt_o       (warn_cnt),
        .fault_cnt_o      (fault_cnt)
    );

    always #5 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // common tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0:       return do_prewarn_o;
            1:       return relay_prewarn_o;
            default: return overload_fault_o;
        endcase
    endfunction

    // bounded wait at falling edges for a chosen output to go high
    task automatic wait_high(input int sel, input int limit);
        int n;
        n = 0;
        while (pick(sel) !== 1'b1) begin
            @(negedge clk_i);
            n++;
            if (n > limit) begin
                check(1'b0, "wait for output timed out");
                close_out();
            end
        end
    endtask

    task automatic drive(input logic [11:0] lvl, input logic [9:0] gain, input logic [6:0] coef,
                         input logic route);
        @(negedge clk_i);
        run_current_i         = lvl;
        overload_time_gain_i  = gain;
        prewarn_coefficient_i = coef;
        prewarn_to_relay_i    = route;
    endtask

    // holds an overload, checks warning and trip times in ticks, then recovers
    task automatic run_trip(input logic [11:0] lvl, input logic [9:0] gain, input logic [6:0] coef,
                            input logic route, input int warn, input int trip);
        drive(lvl, gain, coef, route);
        wait_high(int'(route), (warn + 4) * TCK);
        check(acc_ticks_o >= warn && acc_ticks_o <= warn + 1, "warning time off");
        check(overload_fault_o === (warn == trip), "fault state at warning wrong");
        wait_high(2, (trip - warn + 4) * TCK);
        check(acc_ticks_o >= trip && acc_ticks_o <= trip + 1, "trip time off");
        check(motor_overload_fault_code_o === FAULT_CODE_OVERLOAD, "fault code wrong");
        check(pick(int'(!route)) === 1'b0, "warning on unassigned output");
        drive(12'h000, gain, coef, route);
        repeat (4) @(negedge clk_i);
        check(acc_ticks_o === 16'h0000, "accumulation not cleared");
        check(overload_fault_o === 1'b1, "fault not latched");
        fault_clear_i = 1'b1;
        @(negedge clk_i);
        fault_clear_i = 1'b0;
        repeat (3) @(negedge clk_i);
        check(overload_fault_o === 1'b0, "fault not cleared");
        check(motor_overload_fault_code_o === FAULT_CODE_NONE, "code not cleared");
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic scn_enable();
        overload_protect_enable_i = 1'b0;
        drive(LVL_175, 10'h014, 7'h64, 1'b0);
        repeat (300 * TCK) @(negedge clk_i);
        check(overload_fault_o === 1'b0 && acc_ticks_o === 16'h0000, "tripped while off");
        check(do_prewarn_o === 1'b0 && relay_prewarn_o === 1'b0, "warned while off");
        overload_protect_enable_i = 1'b1;
        wait_high(2, 260 * TCK);
        overload_protect_enable_i = 1'b0;
        repeat (3) @(negedge clk_i);
        check(overload_fault_o === 1'b0, "fault kept after disable");
        overload_protect_enable_i = 1'b1;
        drive(12'h000, 10'h000, 7'h00, 1'b0);
        repeat (4) @(negedge clk_i);
    endtask

    task automatic scn_below();
        drive(LVL_115 - 12'h001, 10'h014, 7'h00, 1'b0);
        repeat (100) @(negedge clk_i);
        check(acc_ticks_o === 16'h0000, "accumulating below curve");
    endtask

    // one cycle at each curve point except 155 % and at the gain floor, gain ceiling and 80 minute clamp, watched by the design assertions
    task automatic scn_points();
        drive(LVL_125, 10'h000, 7'h00, 1'b0);
        drive(12'h5DC, 10'h000, 7'h00, 1'b0);
        drive(12'h5DC, 10'h028, 7'h00, 1'b0);
        drive(LVL_145, 10'h000, 7'h00, 1'b0);
        drive(LVL_175, 10'h005, 7'h00, 1'b0);
        drive(LVL_175, 10'h000, 7'h00, 1'b0);
        drive(LVL_115, 10'h000, 7'h00, 1'b0);
        drive(LVL_115, 10'h3FF, 7'h7F, 1'b0);
        drive(12'h000, 10'h000, 7'h00, 1'b0);
        repeat (4) @(negedge clk_i);
        check(overload_fault_o === 1'b0 && acc_ticks_o === 16'h0000, "spot points left state behind");
    endtask

    task automatic scn_curve();
        run_trip(LVL_175, 10'h014, 7'h64, 1'b0, 240, 240);
        run_trip(12'h5DC, 10'h014, 7'h00, 1'b1, 480, 600);
        run_trip(LVL_155, 10'h014, 7'h00, 1'b0, 384, 480);
        run_trip(LVL_125, 10'h014, 7'h32, 1'b1, 2400, 4800);
        run_trip(LVL_145, 10'h000, 7'h1E, 1'b0, 1800, 3600);
        run_trip(LVL_115, 10'h014, 7'h64, 1'b1, 9600, 9600);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_i                     = 1'b0;
        sys_rst_i                 = 1'b1;
        run_current_i             = 12'h000;
        overload_protect_enable_i = 1'b1;
        overload_time_gain_i      = 10'h000;
        prewarn_coefficient_i     = 7'h00;
        prewarn_to_relay_i        = 1'b0;
        fault_clear_i             = 1'b0;
        num_errors                = 0;
        tests_run                 = 0;
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        @(negedge clk_i);
        check(overload_fault_o === 1'b0 && acc_ticks_o === 16'h0000, "outputs not reset");
        scn_enable();
        scn_below();
        scn_points();
        scn_curve();
        check(fault_cnt === 8'h07 && warn_cnt === 8'h07, "event count at control side wrong");
        close_out();
    end
endmodule
`default_nettype wire
